// [include/spec_xlate_pkg.sv]
// Purpose: constants for the speculative instruction page translation front end
// Assumes: 32-bit effective addresses, 4 KiB pages, 16-entry direct-mapped buffer
// Notes: translation buffer contents are loaded by the core's miss handler
//
// Summary of operation
// - present each fetch using previous page
// - page changed: reissue with correct page
// - tell cache to discard wrong-page result
// - buffer miss: no reissue, abort access
// - stay inactive until core flow abort
`default_nettype none
package spec_xlate_pkg;
  localparam int ADDR_W = 32;
  localparam int OFF_W = 12;
  localparam int PAGE_W = ADDR_W - OFF_W;
  localparam int IDX_W = 4;
  localparam int ENTRIES = 16;
  localparam int TAG_W = PAGE_W - IDX_W;
  // entry: valid, tag, physical page
  localparam int ENTRY_W = 1 + TAG_W + PAGE_W;
  localparam logic [PAGE_W-1:0] PAGE_RST = 20'h00000;
  localparam logic [ENTRY_W-1:0] ENTRY_RST = 37'h0000000000;
endpackage
`default_nettype wire

// [design/xlate_store.sv]
// Purpose: translation buffer storage, registered read
// Assumes: one write and one read port, same clock
// Notes: read data appears one cycle after the read index
`timescale 1ns/1ns
`default_nettype none
module xlate_store (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [spec_xlate_pkg::IDX_W-1:0] rd_idx,
  output logic [spec_xlate_pkg::ENTRY_W-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [spec_xlate_pkg::IDX_W-1:0] wr_idx,
  input wire logic [spec_xlate_pkg::ENTRY_W-1:0] wr_data
);
  logic [spec_xlate_pkg::ENTRY_W-1:0] mem_q [spec_xlate_pkg::ENTRIES];

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < spec_xlate_pkg::ENTRIES; i++) begin
        mem_q[i] <= spec_xlate_pkg::ENTRY_RST;
      end
      rd_data <= spec_xlate_pkg::ENTRY_RST;
    end else begin
      if (wr_en) begin
        mem_q[wr_idx] <= wr_data;
      end
      rd_data <= mem_q[rd_idx];
    end
  end
endmodule
`default_nettype wire

// [design/spec_xlate.sv]
// Purpose: speculative instruction page translation between fetch and cache
// Assumes: core holds FETCH_VALID and FETCH_ADDR until FETCH_DONE
// Notes: cache access goes out on the old page at once, checked a cycle later
`timescale 1ns/1ns
`default_nettype none
module spec_xlate (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic FETCH_VALID,
  input wire logic [spec_xlate_pkg::ADDR_W-1:0] FETCH_ADDR,
  input wire logic FLOW_ABORT,
  input wire logic SHOW_EN,
  input wire logic LOAD_EN,
  input wire logic [spec_xlate_pkg::PAGE_W-1:0] LOAD_VPAGE,
  input wire logic [spec_xlate_pkg::PAGE_W-1:0] LOAD_PPAGE,
  output logic FETCH_DONE,
  output logic XLATE_MISS,
  output logic CACHE_REQ,
  output logic [spec_xlate_pkg::ADDR_W-1:0] CACHE_ADDR,
  output logic CACHE_DISCARD,
  output logic CACHE_ABORT,
  output logic SHOW_REQ,
  output logic [spec_xlate_pkg::ADDR_W-1:0] SHOW_ADDR,
  output logic ACTIVE
);
  typedef enum logic [1:0] {IDLE, CHECK, RETRY, STOPPED} mode_e;

  typedef struct packed {
    mode_e mode;
    logic [spec_xlate_pkg::PAGE_W-1:0] vpage;
    logic [spec_xlate_pkg::PAGE_W-1:0] ppage;
    logic [spec_xlate_pkg::ADDR_W-1:0] addr;
    logic done;
    logic miss;
    logic req;
    logic [spec_xlate_pkg::ADDR_W-1:0] caddr;
    logic discard;
    logic abort;
    logic show;
    logic [spec_xlate_pkg::ADDR_W-1:0] saddr;
    logic pvalid;
    logic active;
  } state_s;

  state_s s_q, s_d;
  logic [spec_xlate_pkg::ENTRY_W-1:0] rd_data;
  logic hit;
  logic [spec_xlate_pkg::PAGE_W-1:0] hit_ppage;

  function automatic logic [spec_xlate_pkg::PAGE_W-1:0] vpage_of(
    input logic [spec_xlate_pkg::ADDR_W-1:0] a);
    vpage_of = a[spec_xlate_pkg::ADDR_W-1:spec_xlate_pkg::OFF_W];
  endfunction

  function automatic logic [spec_xlate_pkg::IDX_W-1:0] idx_of(
    input logic [spec_xlate_pkg::PAGE_W-1:0] p);
    idx_of = p[spec_xlate_pkg::IDX_W-1:0];
  endfunction

  function automatic logic [spec_xlate_pkg::ADDR_W-1:0] join_addr(
    input logic [spec_xlate_pkg::PAGE_W-1:0] p,
    input logic [spec_xlate_pkg::ADDR_W-1:0] a);
    join_addr = {p, a[spec_xlate_pkg::OFF_W-1:0]};
  endfunction

  // =====================================================================
  // translation buffer
  xlate_store u_store (
    .core_clk(CORE_CLK),
    .reset_n(RESET_N),
    .rd_idx(idx_of(vpage_of(FETCH_ADDR))),
    .rd_data(rd_data),
    .wr_en(LOAD_EN),
    .wr_idx(idx_of(LOAD_VPAGE)),
    .wr_data({1'b1, LOAD_VPAGE[spec_xlate_pkg::PAGE_W-1:spec_xlate_pkg::IDX_W], LOAD_PPAGE})
  );

  assign hit = rd_data[spec_xlate_pkg::ENTRY_W-1] &&
    (rd_data[spec_xlate_pkg::ENTRY_W-2:spec_xlate_pkg::PAGE_W] ==
     s_q.addr[spec_xlate_pkg::ADDR_W-1:spec_xlate_pkg::OFF_W+spec_xlate_pkg::IDX_W]);
  assign hit_ppage = rd_data[spec_xlate_pkg::PAGE_W-1:0];

  // =====================================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.miss = 1'b0;
    s_d.req = 1'b0;
    s_d.discard = 1'b0;
    s_d.abort = 1'b0;
    s_d.show = 1'b0;
    case (s_q.mode)
      IDLE: begin
        if (FETCH_VALID && !s_q.done) begin
          s_d.addr = FETCH_ADDR;
          s_d.req = 1'b1;
          s_d.caddr = join_addr(s_q.ppage, FETCH_ADDR);
          s_d.mode = CHECK;
        end
      end
      CHECK: begin
        if (FLOW_ABORT) begin
          s_d.abort = 1'b1;
          s_d.mode = IDLE;
        end else if (s_q.pvalid && vpage_of(s_q.addr) == s_q.vpage) begin
          s_d.done = 1'b1;
          s_d.show = SHOW_EN;
          s_d.saddr = s_q.caddr;
          s_d.mode = IDLE;
        end else if (hit) begin
          s_d.req = 1'b1;
          s_d.caddr = join_addr(hit_ppage, s_q.addr);
          s_d.vpage = vpage_of(s_q.addr);
          s_d.ppage = hit_ppage;
          s_d.pvalid = 1'b1;
          s_d.discard = 1'b1;
          s_d.mode = RETRY;
        end else begin
          s_d.abort = 1'b1;
          s_d.miss = 1'b1;
          s_d.mode = STOPPED;
        end
      end
      RETRY: begin
        if (FLOW_ABORT) begin
          s_d.abort = 1'b1;
        end else begin
          s_d.done = 1'b1;
          s_d.show = SHOW_EN;
          s_d.saddr = s_q.caddr;
        end
        s_d.mode = IDLE;
      end
      STOPPED: begin
        if (FLOW_ABORT) begin
          // stored page untrusted, next fetch looks up
          s_d.pvalid = 1'b0;
          s_d.mode = IDLE;
        end
      end
      default: s_d.mode = IDLE;
    endcase
    // registered inverse of the stop state
    s_d.active = (s_d.mode != STOPPED);
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      s_q <= '0;
      s_q.mode <= IDLE;
      // page marked invalid, first fetch looks up
      s_q.vpage <= spec_xlate_pkg::PAGE_RST;
      s_q.active <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign FETCH_DONE = s_q.done;
  assign XLATE_MISS = s_q.miss;
  assign CACHE_REQ = s_q.req;
  assign CACHE_ADDR = s_q.caddr;
  assign CACHE_DISCARD = s_q.discard;
  assign CACHE_ABORT = s_q.abort;
  assign SHOW_REQ = s_q.show;
  assign SHOW_ADDR = s_q.saddr;
  assign ACTIVE = s_q.active;

  // =====================================================================
  // checks
  // request one cycle after fetch
  a_spec_issue: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (s_q.mode == IDLE && FETCH_VALID && !s_q.done) |=> CACHE_REQ && s_q.mode == CHECK)
    else $error("fetch not issued speculatively");
  // retry uses the looked up page
  a_retry_page: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CACHE_DISCARD |-> CACHE_REQ && CACHE_ADDR[31:12] == s_q.ppage)
    else $error("reissue not on translated page");
  a_discard_pair: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CACHE_DISCARD |-> ##1 (FETCH_DONE || CACHE_ABORT))
    else $error("discard without completion");
  a_miss_abort: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    XLATE_MISS |-> CACHE_ABORT && !CACHE_REQ && !ACTIVE)
    else $error("miss did not abort");
  a_stop_quiet: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (!ACTIVE && !FLOW_ABORT) |=> !ACTIVE && !CACHE_REQ)
    else $error("left stop without flow abort");
  a_stop_release: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (!ACTIVE && FLOW_ABORT) |=> ACTIVE)
    else $error("flow abort ignored");
  a_show_clean: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    SHOW_REQ |-> FETCH_DONE && !CACHE_ABORT && !CACHE_DISCARD)
    else $error("show cycle on cancelled access");
  a_show_gate: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    FETCH_DONE |-> SHOW_REQ == $past(SHOW_EN))
    else $error("show cycle gating wrong");
endmodule
`default_nettype wire

// [dv/core_fetch_model.sv]
// Purpose: core side model, answers a translation miss with a flow abort
// Assumes: miss arrives as a one-cycle pulse
// Notes: delay in cycles set by the bench
`timescale 1ns/1ns
`default_nettype none
module core_fetch_model (
  input wire logic clk,
  input wire logic miss,
  input wire logic kick,
  input wire logic [3:0] dly,
  output logic flow_abort
);
  // ==========
  // flow abort
  // change of flow after miss or kick
  initial begin
    int n;
    flow_abort = 1'b0;
    forever begin
      @(posedge clk);
      if (miss === 1'b1 || kick === 1'b1) begin
        n = (miss === 1'b1) ? dly + 1 : 1;
        repeat (n) @(negedge clk);
        flow_abort = 1'b1;
        @(negedge clk);
        flow_abort = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/tb.sv]
// Purpose: self-checking bench for the speculative page translation
// Assumes: inputs driven at falling edge
// Notes: buffer loaded by the bench
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk, rst_n, fv, ab, sen, ld, kick;
  logic done, miss, req, disc, cab, sreq, act;
  logic [31:0] fa, caddr, saddr;
  logic [19:0] lv, lp, prev;
  logic [3:0] dly;
  int n_errors, n_tests;
  spec_xlate dut_u (.CORE_CLK(clk), .RESET_N(rst_n), .FETCH_VALID(fv), .FETCH_ADDR(fa),
    .FLOW_ABORT(ab), .SHOW_EN(sen), .LOAD_EN(ld), .LOAD_VPAGE(lv), .LOAD_PPAGE(lp),
    .FETCH_DONE(done), .XLATE_MISS(miss), .CACHE_REQ(req), .CACHE_ADDR(caddr),
    .CACHE_DISCARD(disc), .CACHE_ABORT(cab), .SHOW_REQ(sreq), .SHOW_ADDR(saddr),
    .ACTIVE(act));
  core_fetch_model core_u (.clk(clk), .miss(miss), .kick(kick), .dly(dly), .flow_abort(ab));
  // ==========
  // helpers
  task automatic complete_run;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (!ok) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic load(input logic [19:0] v, input logic [19:0] p);
    @(negedge clk);
    ld = 1'b1;
    lv = v;
    lp = p;
    @(negedge clk);
    ld = 1'b0;
  endtask
  // kind: 0 same page, 1 new page hit, 2 miss, 3 abort at check, 4 abort at retry
  task automatic fetch(input logic [31:0] a, input int kind, input logic [19:0] pp);
    logic [5:0] exp;
    @(negedge clk);
    fv = 1'b1;
    fa = a;
    kick = kind == 3;
    for (int k = 1; k <= 4; k++) begin
      @(negedge clk);
      kick = kind == 4 && k == 1;
      exp[5] = k == 1 || ((kind == 1 || kind == 4) && k == 2);
      exp[4] = (kind == 1 || kind == 4) && k == 2;
      exp[3] = (kind == 0 && k == 2) || (kind == 1 && k == 3);
      exp[2] = kind == 2 && k == 2;
      exp[1] = exp[2] || (kind == 3 && k == 2) || (kind == 4 && k == 3);
      exp[0] = exp[3] && sen;
      chk({req, disc, done, miss, cab, sreq} === exp, "pulse pattern");
      if (k == 1) chk(caddr === {prev, a[11:0]}, "speculative address");
      if (exp[4]) chk(caddr === {pp, a[11:0]}, "reissue address");
      if (exp[0]) chk(saddr === {pp, a[11:0]}, "show address");
      if (exp[3] || exp[1]) fv = 1'b0;
    end
    if (kind == 2) chk(act === 1'b0, "active after miss");
    if (kind != 2 && kind != 3) prev = pp;
    $display("fetch %h kind %0d ended", a, kind);
  endtask
  task automatic stop_test;
    int seen;
    int i;
    seen = 0;
    fv = 1'b1;
    fa = 32'h00002004;
    for (i = 0; i < 30 && act !== 1'b1; i++) begin
      @(negedge clk);
      if (req !== 1'b0) seen++;
    end
    fv = 1'b0;
    chk(seen == 0, "fetch taken while stopped");
    if (i == 30) begin
      chk(1'b0, "no restart after flow abort");
      complete_run;
    end
    $display("stop test ended");
  endtask
  // ==========
  // sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    fv = 1'b0;
    fa = 32'h00000000;
    sen = 1'b1;
    ld = 1'b0;
    lv = 20'h00000;
    lp = 20'h00000;
    dly = 4'h6;
    kick = 1'b0;
    prev = 20'h00000;
    n_errors = 0;
    n_tests = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    load(20'h00001, 20'h00abc);
    load(20'h00002, 20'h00def);
    fetch(32'h00001010, 1, 20'h00abc);
    fetch(32'h00001ffc, 0, 20'h00abc);
    fetch(32'h00002010, 3, 20'h00def);
    sen = 1'b0;
    fetch(32'h00002000, 1, 20'h00def);
    sen = 1'b1;
    fetch(32'h00001020, 4, 20'h00abc);
    fetch(32'h00011000, 2, 20'h00000);
    stop_test;
    fetch(32'h00001500, 1, 20'h00abc);
    complete_run;
  end
endmodule
`default_nettype wire
